// file: draw_engine_defines.vh
`ifndef DRAW_ENGINE_DEFINES_VH
`define DRAW_ENGINE_DEFINES_VH

`define OFF_IO_X 4'h0
`define OFF_IO_Y 4'h1
`define OFF_PLANE_CTRL 4'h2
`define OFF_LINE_PAT 4'h3
`define OFF_PLANE_COLOUR 4'h4
`define OFF_ENDPOINT 4'h5
`define OFF_CURSOR_Y 4'h6
`define OFF_CURSOR_X 4'h7
`define OFF_MEM_WRITE 4'h8
`define OFF_MEM_READ 4'h9
`define OFF_STATUS 4'ha
`define OFF_RDATA 4'hb

`define CTRL_PLANE_EN_LSB 0
`define CTRL_USE_PATTERN_BIT 3
`define CTRL_FILL_EN_BIT 4
`define CTRL_RD_PLANE_LSB 5
`define CTRL_INTENSITY_LSB 8
`define PAT_SEL_LSB 0
`define PAT_SCALE_LSB 4

`define ENDPT_MOVE_BIT 11
`define LAST_WORD 6'h22
`define LAST_LINE 9'h1c6
`define WORD_DOTS_LAST 4'hf

`define CLK_PERIOD_NS 8
`define CONV_MAX_NS 90
`define CONV_MAX_CYCLES (`CONV_MAX_NS / `CLK_PERIOD_NS)

`define RST_PLANE_CTRL 12'h007
`define RST_LINE_PAT 8'h00
`define RST_PLANE_COLOUR 9'h0e4

`endif

// file: draw_host_model.sv
`timescale 1ns/1ps
module draw_host_model (
  // Clock
  input wire clk_i,
  // Macro-command port towards the engine
  output logic [3:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire [15:0] rdata_i
);
  initial
  begin
    addr_o = 4'h0;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      // Released data is inverted so a stale value never looks valid
      wdata_o <= ~d;
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    begin
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1;
      d = rdata_i;
    end
  endtask

  // X word carries the move flag; the Y word starts the action
  task automatic endpoint(input logic [9:0] x, input logic [8:0] y,
                          input logic mv);
    begin
      wr(4'h5, {4'h0, mv, 1'b0, x});
      wr(4'h5, {7'h00, y});
    end
  endtask
endmodule

// file: graphics_draw_engine.v
`timescale 1ns/1ps
`include "draw_engine_defines.vh"
module graphics_draw_engine (
  // Clock and reset
  input wire REF_CLK_I,
  input wire NRST_I,
  // Host macro-command port
  input wire [3:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output wire [15:0] RDATA_O,
  // Display timing, same clock domain
  input wire HBLANK_I,
  input wire VBLANK_I,
  input wire [8:0] DISP_Y_I,
  // Graphics memory
  output wire [6:0] MEM_ADDR_O,
  output wire RAS_N_O,
  output wire CAS_N_O,
  output wire WE_N_O,
  output wire [2:0] PLANE_WE_O,
  output wire [15:0] MEM_WDATA_O,
  output wire [15:0] BIT_MASK_O,
  input wire [47:0] MEM_RDATA_I,
  // Cursor, colour and status
  output wire [9:0] CURSOR_X_O,
  output wire [8:0] CURSOR_Y_O,
  output wire [8:0] PLANE_COLOUR_O,
  output wire VECTOR_DONE_O
);
  localparam [5:0] M_IDLE = 6'h01;
  localparam [5:0] M_CONV = 6'h02;
  localparam [5:0] M_ROWA = 6'h04;
  localparam [5:0] M_RAS = 6'h08;
  localparam [5:0] M_CAS = 6'h10;
  localparam [5:0] M_END = 6'h20;
  localparam [4:0] V_IDLE = 5'h01;
  localparam [4:0] V_SETUP = 5'h02;
  localparam [4:0] V_PLOT = 5'h04;
  localparam [4:0] V_WAIT = 5'h08;
  localparam [4:0] V_STEP = 5'h10;
  localparam [2:0] SRC_DISP = 3'h1;
  localparam [2:0] SRC_IO = 3'h2;
  localparam [2:0] SRC_VEC = 3'h4;

  // Fill cell numbering, dither order
  function [3:0] cell_number;
    input [1:0] cy;
    input [1:0] cx;
    begin
      case ({cy, cx})
        4'h0: cell_number = 4'h0;
        4'h1: cell_number = 4'h8;
        4'h2: cell_number = 4'h2;
        4'h3: cell_number = 4'ha;
        4'h4: cell_number = 4'hc;
        4'h5: cell_number = 4'h4;
        4'h6: cell_number = 4'he;
        4'h7: cell_number = 4'h6;
        4'h8: cell_number = 4'h3;
        4'h9: cell_number = 4'hb;
        4'ha: cell_number = 4'h1;
        4'hb: cell_number = 4'h9;
        4'hc: cell_number = 4'hf;
        4'hd: cell_number = 4'h7;
        4'he: cell_number = 4'hd;
        default: cell_number = 4'h5;
      endcase
    end
  endfunction

  function [15:0] pattern_rom;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: pattern_rom = 16'hffff;
        4'h1: pattern_rom = 16'hff00;
        4'h2: pattern_rom = 16'hf0f0;
        4'h3: pattern_rom = 16'hcccc;
        4'h4: pattern_rom = 16'haaaa;
        4'h5: pattern_rom = 16'hfff0;
        4'h6: pattern_rom = 16'hff18;
        4'h7: pattern_rom = 16'hfe38;
        4'h8: pattern_rom = 16'hf000;
        4'h9: pattern_rom = 16'hffcc;
        4'ha: pattern_rom = 16'hfc30;
        4'hb: pattern_rom = 16'h8080;
        4'hc: pattern_rom = 16'hfffc;
        4'hd: pattern_rom = 16'he4e4;
        4'he: pattern_rom = 16'hf8f8;
        default: pattern_rom = 16'h0000;
      endcase
    end
  endfunction

  reg [5:0] io_x_reg;
  reg [8:0] io_y_reg;
  reg [11:0] ctrl_reg;
  reg [7:0] pat_reg;
  reg [8:0] colour_reg;
  reg [9:0] cursor_x_reg;
  reg [8:0] cursor_y_reg;
  reg [15:0] io_wdata_reg;
  reg [15:0] io_rdata_reg;
  reg io_pend_reg;
  reg io_write_reg;
  reg [15:0] rdata_reg;
  reg [9:0] ep_x_reg;
  reg ep_move_reg;
  reg ep_half_reg;
  reg ep_go_reg;
  reg [9:0] pen_x_reg;
  reg [8:0] pen_y_reg;
  reg [9:0] end_x_reg;
  reg [8:0] end_y_reg;
  reg major_x_reg;
  reg neg_x_reg;
  reg neg_y_reg;
  reg [10:0] maj_reg;
  reg [10:0] min_reg;
  reg [10:0] frac_reg;
  reg [10:0] count_reg;
  reg [3:0] pat_idx_reg;
  reg [3:0] rep_reg;
  reg vec_pend_reg;
  reg vec_done_reg;
  reg [4:0] vstate_reg;
  reg [3:0] dot_div_reg;
  reg [5:0] disp_x_reg;
  reg disp_pend_reg;
  reg [5:0] mstate_reg;
  reg [2:0] src_reg;
  reg [8:0] conv_y_reg;
  reg [5:0] conv_x_reg;
  reg [6:0] mem_addr_reg;
  reg ras_n_reg;
  reg cas_n_reg;
  reg we_n_reg;
  reg [2:0] plane_we_reg;
  reg [15:0] mem_wdata_reg;
  reg [15:0] bit_mask_reg;
  wire [13:0] word_addr;
  wire blanking;
  wire wr_any;
  wire cycle_end;
  wire [10:0] dx;
  wire [10:0] dy;
  wire [10:0] adx;
  wire [10:0] ady;
  wire [11:0] frac_sum;
  wire [15:0] pat_bits;
  wire dot_value;

  assign blanking = HBLANK_I | VBLANK_I;
  assign wr_any = WR_I;
  assign cycle_end = (mstate_reg == M_END);
  assign dx = {1'b0, end_x_reg} - {1'b0, pen_x_reg};
  assign dy = {2'b00, end_y_reg} - {2'b00, pen_y_reg};
  assign adx = dx[10] ? (11'h000 - dx) : dx;
  assign ady = dy[10] ? (11'h000 - dy) : dy;
  assign frac_sum = {1'b0, frac_reg} + {1'b0, min_reg};
  assign pat_bits = pattern_rom(pat_reg[`PAT_SEL_LSB +: 4]);
  assign dot_value = ctrl_reg[`CTRL_FILL_EN_BIT] ?
    (cell_number(pen_y_reg[1:0], pen_x_reg[1:0]) <=
     ctrl_reg[`CTRL_INTENSITY_LSB +: 4]) :
    (ctrl_reg[`CTRL_USE_PATTERN_BIT] ? pat_bits[pat_idx_reg] : 1'b1);

  word_address_converter u_conv (
    .clk_i(REF_CLK_I),
    .nrst_i(NRST_I),
    .y_i(conv_y_reg),
    .x_i(conv_x_reg),
    .addr_o(word_addr)
  );

  // Host commands, I/O counters and read port
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      io_x_reg <= 6'h00;
      io_y_reg <= 9'h000;
      ctrl_reg <= `RST_PLANE_CTRL;
      pat_reg <= `RST_LINE_PAT;
      colour_reg <= `RST_PLANE_COLOUR;
      cursor_x_reg <= 10'h000;
      cursor_y_reg <= 9'h000;
      io_wdata_reg <= 16'h0000;
      io_pend_reg <= 1'b0;
      io_write_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      ep_x_reg <= 10'h000;
      ep_move_reg <= 1'b0;
      ep_half_reg <= 1'b0;
      ep_go_reg <= 1'b0;
      end_y_reg <= 9'h000;
    end
    else
    begin
      ep_go_reg <= 1'b0;
      if (cycle_end && src_reg == SRC_IO)
      begin
        io_pend_reg <= 1'b0;
        if (io_x_reg == `LAST_WORD)
        begin
          io_x_reg <= 6'h00;
          io_y_reg <= (io_y_reg == `LAST_LINE) ? 9'h000 : io_y_reg + 9'h001;
        end
        else
          io_x_reg <= io_x_reg + 6'h01;
      end
      if (wr_any)
      begin
        case (ADDR_I)
          `OFF_IO_X: io_x_reg <= WDATA_I[5:0];
          `OFF_IO_Y: io_y_reg <= WDATA_I[8:0];
          `OFF_PLANE_CTRL: ctrl_reg <= WDATA_I[11:0];
          `OFF_LINE_PAT: pat_reg <= WDATA_I[7:0];
          `OFF_PLANE_COLOUR: colour_reg <= WDATA_I[8:0];
          `OFF_CURSOR_Y: cursor_y_reg <= WDATA_I[8:0];
          `OFF_CURSOR_X: cursor_x_reg <= WDATA_I[9:0];
          `OFF_ENDPOINT:
            if (vstate_reg == V_IDLE && !ep_go_reg)
            begin
              if (!ep_half_reg)
              begin
                ep_x_reg <= WDATA_I[9:0];
                ep_move_reg <= WDATA_I[`ENDPT_MOVE_BIT];
                ep_half_reg <= 1'b1;
              end
              else
              begin
                end_y_reg <= WDATA_I[8:0];
                ep_half_reg <= 1'b0;
                ep_go_reg <= 1'b1;
              end
            end
          `OFF_MEM_WRITE:
            if (!io_pend_reg)
            begin
              io_wdata_reg <= WDATA_I;
              io_write_reg <= 1'b1;
              io_pend_reg <= 1'b1;
            end
          `OFF_MEM_READ:
            if (!io_pend_reg)
            begin
              io_write_reg <= 1'b0;
              io_pend_reg <= 1'b1;
            end
          default: ;
        endcase
      end
      if (RD_I)
      begin
        case (ADDR_I)
          `OFF_IO_X: rdata_reg <= {10'h000, io_x_reg};
          `OFF_IO_Y: rdata_reg <= {7'h00, io_y_reg};
          `OFF_PLANE_CTRL: rdata_reg <= {4'h0, ctrl_reg};
          `OFF_LINE_PAT: rdata_reg <= {8'h00, pat_reg};
          `OFF_PLANE_COLOUR: rdata_reg <= {7'h00, colour_reg};
          `OFF_CURSOR_Y: rdata_reg <= {7'h00, cursor_y_reg};
          `OFF_CURSOR_X: rdata_reg <= {6'h00, cursor_x_reg};
          `OFF_STATUS: rdata_reg <= {13'h0000, io_pend_reg,
            (vstate_reg != V_IDLE), vec_done_reg};
          `OFF_RDATA: rdata_reg <= io_rdata_reg;
          default: rdata_reg <= 16'h0000;
        endcase
      end
    end
  end

  // Vector generator
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      vstate_reg <= V_IDLE;
      pen_x_reg <= 10'h000;
      pen_y_reg <= 9'h000;
      end_x_reg <= 10'h000;
      major_x_reg <= 1'b1;
      neg_x_reg <= 1'b0;
      neg_y_reg <= 1'b0;
      maj_reg <= 11'h000;
      min_reg <= 11'h000;
      frac_reg <= 11'h000;
      count_reg <= 11'h000;
      pat_idx_reg <= 4'h0;
      rep_reg <= 4'h0;
      vec_pend_reg <= 1'b0;
      vec_done_reg <= 1'b0;
    end
    else
    begin
      case (vstate_reg)
        V_IDLE:
          if (ep_go_reg)
          begin
            vec_done_reg <= 1'b0;
            end_x_reg <= ep_x_reg;
            if (ep_move_reg)
            begin
              pen_x_reg <= ep_x_reg;
              pen_y_reg <= end_y_reg;
              vec_done_reg <= 1'b1;
            end
            else
              vstate_reg <= V_SETUP;
          end
        V_SETUP:
        begin
          major_x_reg <= (adx >= ady);
          maj_reg <= (adx >= ady) ? adx : ady;
          min_reg <= (adx >= ady) ? ady : adx;
          frac_reg <= ((adx >= ady) ? adx : ady) >> 1;
          count_reg <= (adx >= ady) ? adx : ady;
          neg_x_reg <= dx[10];
          neg_y_reg <= dy[10];
          pat_idx_reg <= 4'h0;
          rep_reg <= 4'h0;
          vstate_reg <= V_PLOT;
        end
        V_PLOT:
        begin
          vec_pend_reg <= 1'b1;
          vstate_reg <= V_WAIT;
        end
        V_WAIT:
          if (cycle_end && src_reg == SRC_VEC)
          begin
            vec_pend_reg <= 1'b0;
            if (rep_reg == pat_reg[`PAT_SCALE_LSB +: 4])
            begin
              rep_reg <= 4'h0;
              pat_idx_reg <= pat_idx_reg - 4'h1;
            end
            else
              rep_reg <= rep_reg + 4'h1;
            if (count_reg == 11'h000)
            begin
              vec_done_reg <= 1'b1;
              vstate_reg <= V_IDLE;
            end
            else
              vstate_reg <= V_STEP;
          end
        V_STEP:
        begin
          count_reg <= count_reg - 11'h001;
          // Fraction scaled by the major delta, so no divider is needed
          if (frac_sum >= {1'b0, maj_reg})
            frac_reg <= frac_sum[10:0] - maj_reg;
          else
            frac_reg <= frac_sum[10:0];
          if (major_x_reg || frac_sum >= {1'b0, maj_reg})
            pen_x_reg <= neg_x_reg ? pen_x_reg - 10'h001 :
              pen_x_reg + 10'h001;
          if (!major_x_reg || frac_sum >= {1'b0, maj_reg})
            pen_y_reg <= neg_y_reg ? pen_y_reg - 9'h001 : pen_y_reg + 9'h001;
          vstate_reg <= V_PLOT;
        end
        default: vstate_reg <= V_IDLE;
      endcase
    end
  end

  // Display word counter follows the scan, one word per 16 dots
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      dot_div_reg <= 4'h0;
      disp_x_reg <= 6'h00;
      disp_pend_reg <= 1'b0;
    end
    else if (blanking)
    begin
      dot_div_reg <= 4'h0;
      disp_x_reg <= 6'h00;
      disp_pend_reg <= 1'b0;
    end
    else
    begin
      dot_div_reg <= dot_div_reg + 4'h1;
      if (dot_div_reg == 4'h0)
        disp_pend_reg <= 1'b1;
      else if (cycle_end && src_reg == SRC_DISP)
        disp_pend_reg <= 1'b0;
      if (dot_div_reg == `WORD_DOTS_LAST)
        disp_x_reg <= disp_x_reg + 6'h01;
    end
  end

  // Memory cycle sequencer
  always @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      mstate_reg <= M_IDLE;
      src_reg <= SRC_DISP;
      conv_y_reg <= 9'h000;
      conv_x_reg <= 6'h00;
      mem_addr_reg <= 7'h00;
      ras_n_reg <= 1'b1;
      cas_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      plane_we_reg <= 3'h0;
      mem_wdata_reg <= 16'h0000;
      bit_mask_reg <= 16'h0000;
      io_rdata_reg <= 16'h0000;
    end
    else
    begin
      case (mstate_reg)
        M_IDLE:
          if (!blanking && disp_pend_reg)
          begin
            src_reg <= SRC_DISP;
            conv_y_reg <= DISP_Y_I;
            conv_x_reg <= disp_x_reg;
            mstate_reg <= M_CONV;
          end
          else if (blanking && vec_pend_reg)
          begin
            src_reg <= SRC_VEC;
            conv_y_reg <= pen_y_reg;
            conv_x_reg <= pen_x_reg[9:4];
            mem_wdata_reg <= {16{dot_value}};
            bit_mask_reg <= 16'h0001 << pen_x_reg[3:0];
            mstate_reg <= M_CONV;
          end
          else if (blanking && io_pend_reg)
          begin
            src_reg <= SRC_IO;
            conv_y_reg <= io_y_reg;
            conv_x_reg <= io_x_reg;
            mem_wdata_reg <= io_wdata_reg;
            bit_mask_reg <= 16'hffff;
            mstate_reg <= M_CONV;
          end
        M_CONV: mstate_reg <= M_ROWA;
        M_ROWA:
        begin
          mem_addr_reg <= word_addr[6:0];
          we_n_reg <= ~((src_reg == SRC_VEC) ||
            (src_reg == SRC_IO && io_write_reg));
          plane_we_reg <= (src_reg == SRC_DISP ||
            (src_reg == SRC_IO && !io_write_reg)) ? 3'h0 :
            ctrl_reg[`CTRL_PLANE_EN_LSB +: 3];
          mstate_reg <= M_RAS;
        end
        M_RAS:
        begin
          ras_n_reg <= 1'b0;
          mem_addr_reg <= word_addr[13:7];
          mstate_reg <= M_CAS;
        end
        M_CAS:
        begin
          cas_n_reg <= 1'b0;
          mstate_reg <= M_END;
        end
        M_END:
        begin
          if (src_reg == SRC_IO && !io_write_reg)
            io_rdata_reg <= MEM_RDATA_I[16 * ctrl_reg[`CTRL_RD_PLANE_LSB +: 2]
              +: 16];
          ras_n_reg <= 1'b1;
          cas_n_reg <= 1'b1;
          we_n_reg <= 1'b1;
          plane_we_reg <= 3'h0;
          mstate_reg <= M_IDLE;
        end
        default: mstate_reg <= M_IDLE;
      endcase
    end
  end

  assign RDATA_O = rdata_reg;
  assign MEM_ADDR_O = mem_addr_reg;
  assign RAS_N_O = ras_n_reg;
  assign CAS_N_O = cas_n_reg;
  assign WE_N_O = we_n_reg;
  assign PLANE_WE_O = plane_we_reg;
  assign MEM_WDATA_O = mem_wdata_reg;
  assign BIT_MASK_O = bit_mask_reg;
  assign CURSOR_X_O = cursor_x_reg;
  assign CURSOR_Y_O = cursor_y_reg;
  assign PLANE_COLOUR_O = colour_reg;
  assign VECTOR_DONE_O = vec_done_reg;
endmodule

// file: graphics_draw_engine_assertions.sv
`timescale 1ns/1ps
module graphics_draw_engine_checker (
  // Clock and reset
  input wire REF_CLK_I,
  input wire NRST_I,
  // Host port
  input wire [3:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  // Timing and memory
  input wire HBLANK_I,
  input wire VBLANK_I,
  input wire RAS_N_O,
  input wire CAS_N_O,
  input wire WE_N_O,
  input wire [2:0] PLANE_WE_O,
  input wire [15:0] BIT_MASK_O,
  // Cursor and colour
  input wire [9:0] CURSOR_X_O,
  input wire [8:0] CURSOR_Y_O,
  input wire [8:0] PLANE_COLOUR_O
);
  wire blank = HBLANK_I | VBLANK_I;
  wire [9:0] wd_x = WDATA_I[9:0];
  wire [8:0] wd_9 = WDATA_I[8:0];

  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);

  property p_strobe_seq;
    $fell(RAS_N_O) |-> ##1 ($fell(CAS_N_O) && !RAS_N_O)
      ##1 (RAS_N_O && CAS_N_O);
  endproperty
  a_strobe_seq: assert property (p_strobe_seq)
    else $error("row and column strobe sequence broken");

  property p_we_hold;
    $fell(RAS_N_O) |-> $stable(WE_N_O) [*2];
  endproperty
  a_we_hold: assert property (p_we_hold)
    else $error("write select moved inside a memory cycle");

  property p_read_no_plane;
    !RAS_N_O && WE_N_O |-> PLANE_WE_O == 3'b000;
  endproperty
  a_read_no_plane: assert property (p_read_no_plane)
    else $error("plane write enabled in a read cycle");

  property p_write_blank;
    $fell(RAS_N_O) && !WE_N_O |->
      ($past(blank, 3) || $past(blank, 4) || $past(blank, 5));
  endproperty
  a_write_blank: assert property (p_write_blank)
    else $error("memory write started during active display");

  property p_cursor_x;
    WR_I && ADDR_I == 4'h7 |=> CURSOR_X_O == $past(wd_x);
  endproperty
  a_cursor_x: assert property (p_cursor_x)
    else $error("cursor x not loaded");

  property p_cursor_y;
    WR_I && ADDR_I == 4'h6 |=> CURSOR_Y_O == $past(wd_9);
  endproperty
  a_cursor_y: assert property (p_cursor_y)
    else $error("cursor y not loaded");

  property p_colour;
    WR_I && ADDR_I == 4'h4 |=> PLANE_COLOUR_O == $past(wd_9);
  endproperty
  a_colour: assert property (p_colour)
    else $error("plane colour not loaded");

  property p_cursor_hold;
    !(WR_I && ADDR_I == 4'h7) |=> $stable(CURSOR_X_O);
  endproperty
  a_cursor_hold: assert property (p_cursor_hold)
    else $error("cursor x changed without a load");

  property p_mask;
    !RAS_N_O && !WE_N_O |-> ($onehot(BIT_MASK_O) || BIT_MASK_O == 16'hffff);
  endproperty
  a_mask: assert property (p_mask)
    else $error("write mask neither one bit nor full word");
endmodule

// file: graphics_draw_engine_bench.sv
`timescale 1ns/1ps
module graphics_draw_engine_bench;
  typedef struct packed {logic [3:0] a; logic [15:0] d;
    logic [1:0] sel; logic [9:0] e;} row_t;
  logic clk, rst_n, toggle, hblank, prev_ras;
  logic vsel, vblank;
  logic [5:0] tcnt = 6'h00;
  wire [3:0] addr;
  wire [15:0] wdata, rdata, mem_wdata, mask;
  wire wr, rd, ras_n, cas_n, we_n, done;
  wire [6:0] mem_addr;
  wire [2:0] pwe;
  wire [9:0] cur_x;
  wire [8:0] cur_y, colour;
  int err_total, num_checks, nvec, nrd;
  logic [6:0] prev_addr, w_row, w_col, r_row, r_col;
  logic [15:0] w_data, w_mask, first_mask, s, vbits;
  logic [2:0] w_pwe;
  logic [9:0] got;
  row_t rows [5];

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Toggled retrace keeps vector points waiting for blanking windows
  always @(posedge clk)
  begin
    tcnt <= tcnt + 6'h01;
    // Vertical mode leaves only vertical retrace windows open
    hblank <= toggle ? (tcnt[5] & !vsel) : 1'b1;
    vblank <= toggle & vsel & tcnt[5];
  end

  draw_host_model u_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  graphics_draw_engine u_dut (.REF_CLK_I(clk), .NRST_I(rst_n),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .HBLANK_I(hblank), .VBLANK_I(vblank), .DISP_Y_I(9'h010),
    .MEM_ADDR_O(mem_addr), .RAS_N_O(ras_n), .CAS_N_O(cas_n), .WE_N_O(we_n),
    .PLANE_WE_O(pwe), .MEM_WDATA_O(mem_wdata), .BIT_MASK_O(mask),
    .MEM_RDATA_I(48'h3c3c_a5a5_0f0f), .CURSOR_X_O(cur_x),
    .CURSOR_Y_O(cur_y), .PLANE_COLOUR_O(colour), .VECTOR_DONE_O(done));

  // Row address is the one standing the cycle before the row strobe
  always @(posedge clk)
  begin
    if (prev_ras && !ras_n && !we_n)
    begin
      w_row = prev_addr;
      w_col = mem_addr;
      w_data = mem_wdata;
      w_mask = mask;
      w_pwe = pwe;
      if (mask != 16'hffff)
      begin
        if (nvec == 0)
          first_mask = mask;
        vbits = {vbits[14:0], mem_wdata[0]};
        nvec++;
      end
    end
    else if (prev_ras && !ras_n)
    begin
      // The first read is the I/O read, the second the first display fetch
      if (nrd == 1)
      begin
        r_row = prev_addr;
        r_col = mem_addr;
      end
      nrd++;
    end
    prev_ras = ras_n;
    prev_addr = mem_addr;
  end

  task automatic chk(input string n, input logic [47:0] e,
                     input logic [47:0] g);
    begin
      num_checks++;
      if (g !== e)
      begin
        err_total++;
        $display("mismatch %s expected %h seen %h", n, e, g);
      end
    end
  endtask

  task end_sim;
    begin
      if (err_total == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // Polls status until the masked bits read v, bounded
  task automatic wait_st(input logic [15:0] m, input logic [15:0] v);
    int n;
    begin
      n = 0;
      s = ~v;
      while (((s & m) !== v) && n < 300)
      begin
        u_host.rd(4'ha, s);
        n++;
      end
      if (n >= 300)
        chk("status", 48'(v), 48'(s & m));
    end
  endtask

  initial
  begin
    #(8 * 30000);
    err_total++;
    end_sim;
  end

  initial
  begin
    rst_n = 1'b0;
    toggle = 1'b0;
    vsel = 1'b0;
    nvec = 0;
    nrd = 0;
    err_total = 0;
    num_checks = 0;
    rows = '{'{4'h7, 16'h022f, 2'd0, 10'h22f},
      '{4'h6, 16'h01c6, 2'd1, 10'h1c6}, '{4'h4, 16'h01ab, 2'd2, 10'h1ab},
      '{4'h7, 16'hfd55, 2'd0, 10'h155}, '{4'h4, 16'hfe00, 2'd2, 10'h000}};
    repeat (10) @(posedge clk);
    #1;
    chk("strobes", 48'(3'b111), 48'({ras_n, cas_n, we_n}));
    chk("plane_we", 48'(3'b000), 48'(pwe));
    chk("colour", 48'(9'h0e4), 48'(colour));
    chk("done", 48'(1'b0), 48'(done));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      u_host.wr(rows[i].a, rows[i].d);
      @(posedge clk);
      #1;
      case (rows[i].sel)
        2'd0: got = cur_x;
        2'd1: got = {1'b0, cur_y};
        default: got = {1'b0, colour};
      endcase
      chk("table", 48'(rows[i].e), 48'(got));
    end
    u_host.wr(4'h2, 16'h0007);
    u_host.wr(4'h0, 16'd34);
    u_host.wr(4'h1, 16'd5);
    u_host.wr(4'h8, 16'hbeef);
    wait_st(16'h0004, 16'h0000);
    chk("io_row", 48'(7'h51), 48'(w_row));
    chk("io_col", 48'(7'h01), 48'(w_col));
    chk("io_data", 48'hbeef, 48'(w_data));
    chk("io_mask", 48'hffff, 48'(w_mask));
    chk("io_planes", 48'(3'b111), 48'(w_pwe));
    u_host.wr(4'h8, 16'h1234);
    wait_st(16'h0004, 16'h0000);
    chk("io_next_row", 48'(7'h52), 48'(w_row));
    chk("io_next_col", 48'(7'h01), 48'(w_col));
    u_host.wr(4'h2, 16'h0027);
    u_host.wr(4'h9, 16'h0000);
    wait_st(16'h0004, 16'h0000);
    u_host.rd(4'hb, s);
    chk("read_plane", 48'ha5a5, 48'(s));
    u_host.endpoint(10'h000, 9'h000, 1'b1);
    wait_st(16'h0003, 16'h0001);
    chk("move_writes", 48'(0), 48'(nvec));
    toggle <= 1'b1;
    u_host.endpoint(10'h005, 9'h002, 1'b0);
    repeat (4) @(posedge clk);
    wait_st(16'h0003, 16'h0001);
    toggle <= 1'b0;
    chk("points", 48'(6), 48'(nvec));
    chk("first_mask", 48'h0001, 48'(first_mask));
    chk("last_mask", 48'h0020, 48'(w_mask));
    chk("last_row", 48'(7'h46), 48'(w_row));
    chk("last_col", 48'(7'h00), 48'(w_col));
    chk("solid_bit", 48'(1'b1), 48'(w_data[5]));
    chk("done_flag", 48'(1'b1), 48'(done));
    chk("disp_row", 48'(7'h30), 48'(r_row));
    chk("disp_col", 48'(7'h04), 48'(r_col));
    toggle <= 1'b1;
    u_host.wr(4'h2, 16'h000f);
    u_host.wr(4'h3, 16'h0014);
    u_host.endpoint(10'h00c, 9'h002, 1'b0);
    repeat (4) @(posedge clk);
    wait_st(16'h0003, 16'h0001);
    // First dot uses pattern bit 0, then 15 downwards, each bit twice
    chk("pattern", 48'h33, 48'(vbits[7:0]));
    vsel <= 1'b1;
    u_host.wr(4'h2, 16'h0717);
    u_host.endpoint(10'h00f, 9'h002, 1'b0);
    repeat (4) @(posedge clk);
    wait_st(16'h0003, 16'h0001);
    chk("fill", 48'ha, 48'(vbits[3:0]));
    chk("fill_points", 48'(18), 48'(nvec));
    toggle <= 1'b0;
    vsel <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("rst_cursor", 48'(0), 48'({cur_x, cur_y}));
    chk("rst_colour", 48'(9'h0e4), 48'(colour));
    chk("rst_done", 48'(0), 48'({done, rdata}));
    end_sim;
  end
endmodule

bind graphics_draw_engine graphics_draw_engine_checker u_chk (
  .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .HBLANK_I(HBLANK_I), .VBLANK_I(VBLANK_I),
  .RAS_N_O(RAS_N_O), .CAS_N_O(CAS_N_O), .WE_N_O(WE_N_O),
  .PLANE_WE_O(PLANE_WE_O), .BIT_MASK_O(BIT_MASK_O),
  .CURSOR_X_O(CURSOR_X_O), .CURSOR_Y_O(CURSOR_Y_O),
  .PLANE_COLOUR_O(PLANE_COLOUR_O));

// file: word_address_converter.v
`timescale 1ns/1ps
module word_address_converter (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // X/Y word address
  input wire [8:0] y_i,
  input wire [5:0] x_i,
  // Absolute word address, one cycle later
  output reg [13:0] addr_o
);
  // 35Y = 32Y + 2Y + Y; max result 15924 fits in 14 bits
  wire [14:0] sum;
  assign sum = {1'b0, y_i[8:0], 5'h00} + {5'h00, y_i, 1'b0} +
    {6'h00, y_i} + {9'h000, x_i};

  // One clock of 8 ns is well inside the allowed conversion time
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      addr_o <= 14'h0000;
    else
      addr_o <= sum[13:0];
  end
endmodule
